// ### hw/capture_channel.sv
// One capture channel: input synchroniser, two-sample filter, edge select, capture latch
`timescale 1ns/10ps
`include "capture_timer_map.svh"
module capture_channel (
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire logic                         pin_in,
  input  wire logic                         tick,
  input  wire logic                         run,
  input  wire capture_timer_pkg::edge_sel_type edge_sel,
  input  wire logic [1:0]                   div_sel,
  input  wire logic                         use_div,
  input  wire logic [15:0]                  count,
  output logic [15:0]                       cap_r,
  output logic                              irq_r
);
  import capture_timer_pkg::*;

  logic [2:0] sync_r;
  logic       samp_r;
  logic       level_r;
  logic [2:0] div_cnt_r;
  logic       edge_hit;
  logic       fire;
  logic [2:0] div_top;

  // ==========================================================================
  // Pin synchroniser: change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  // Sample on the count tick; level moves only after two equal samples
  // Level resets low so a high pin at start looks like a rising edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      samp_r  <= 1'b0;
      level_r <= 1'b0;
    end else if (!run) begin
      samp_r  <= 1'b0;
      level_r <= 1'b0;
    end else if (tick && (sync_r[2] == sync_r[1])) begin
      samp_r <= sync_r[2];
      if (samp_r == sync_r[2]) begin
        level_r <= samp_r;
      end
    end
  end

  // Edge selection; prohibited code never captures
  always_comb begin
    edge_hit = 1'b0;
    if (run && tick && (samp_r == sync_r[2]) && (sync_r[2] == sync_r[1])
        && (samp_r != level_r)) begin
      unique case (edge_sel)
        EDGE_FALL: edge_hit = !samp_r;
        EDGE_RISE: edge_hit = samp_r;
        EDGE_BOTH: edge_hit = 1'b1;
        EDGE_BAD:  edge_hit = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Optional capture divider: every 2^div_sel-th edge captures
  assign div_top = (3'h1 << div_sel) - 3'h1;
  assign fire    = edge_hit && (!use_div || (div_cnt_r == div_top));

  always_ff @(posedge core_clk) begin
    if (!nrst || !run) begin
      div_cnt_r <= 3'h0;
    end else if (edge_hit && use_div) begin
      div_cnt_r <= (div_cnt_r == div_top) ? 3'h0 : div_cnt_r + 3'h1;
    end
  end

  // Capture wins over any read in the same cycle; that read returns the old value
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cap_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      irq_r <= fire;
      if (fire) begin
        cap_r <= count;
      end
    end
  end

  // ==========================================================================
  // Checks: a capture is a request pulse plus the latched count
  sequence s_latched;
    irq_r && (cap_r == $past(count));
  endsequence

  property p_irq_follows_fire;
    @(posedge core_clk) disable iff (!nrst)
    fire |=> s_latched;
  endproperty
  a_irq_follows_fire: assert property (p_irq_follows_fire)
    else $error("capture did not latch count");

  property p_bad_edge_idle;
    @(posedge core_clk) disable iff (!nrst)
    (edge_sel == EDGE_BAD) && ($past(edge_sel) == EDGE_BAD) |-> !edge_hit;
  endproperty
  a_bad_edge_idle: assert property (p_bad_edge_idle)
    else $error("prohibited edge captured");

  // Stopped channel never requests
  property p_stop_no_irq;
    @(posedge core_clk) disable iff (!nrst)
    !run |=> !irq_r;
  endproperty
  a_stop_no_irq: assert property (p_stop_no_irq)
    else $error("request while stopped");

  // Ticks are at least eight clocks apart, so a request is one cycle long
  property p_irq_pulse;
    @(posedge core_clk) disable iff (!nrst)
    irq_r |=> !irq_r;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("request longer than one cycle");

  property p_cap_hold;
    @(posedge core_clk) disable iff (!nrst)
    !fire |=> $stable(cap_r);
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("capture changed without an edge");

  // Edges are only judged on a count tick
  property p_edge_on_tick;
    @(posedge core_clk) disable iff (!nrst)
    !tick |-> !edge_hit;
  endproperty
  a_edge_on_tick: assert property (p_edge_on_tick)
    else $error("edge accepted off a tick");
endmodule : capture_channel

// ### hw/capture_timer.sv
// Top of the three-channel free-running capture timer with its control registers
`timescale 1ns/10ps
`include "capture_timer_map.svh"
module capture_timer (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire capture_timer_pkg::cpu_req_type cpu_req,
  output capture_timer_pkg::cpu_rsp_type     cpu_rsp,
  input  wire logic                          capture_input0,
  input  wire logic                          capture_input1,
  input  wire logic                          capture_input2,
  output logic                               capture_irq0,
  output logic                               capture_irq1,
  output logic                               capture_irq2,
  output logic [15:0]                        free_run_counter
);
  import capture_timer_pkg::*;

  logic [7:0]  mode_control_reg_r;
  logic [7:0]  capture_pulse_control_reg_r;
  logic [7:0]  prescaler_mode_reg_r;
  logic [15:0] count_r;
  logic [`PRESCALE_WIDTH-1:0] presc_r;
  logic        tick;
  logic        run;
  logic [2:0]  pins;
  logic [2:0]  irqs;
  logic [15:0] caps [3];
  cpu_rsp_type rsp_nxt;
  cpu_rsp_type rsp_r;

  assign run = mode_control_reg_r[`RUN_ENABLE_BIT];

  // ==========================================================================
  // Control registers; unused bits are forced to zero on write
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode_control_reg_r          <= `CTRL_RESET;
      capture_pulse_control_reg_r <= `CTRL_RESET;
      prescaler_mode_reg_r        <= `CTRL_RESET;
    end else if (cpu_req.wr) begin
      unique case (cpu_req.addr)
        `MODE_CONTROL_ADDR: mode_control_reg_r <= cpu_req.wdata & `MODE_CONTROL_MASK;
        `CAPTURE_DIV_ADDR:  capture_pulse_control_reg_r <= cpu_req.wdata & `CAPTURE_DIV_MASK;
        `PRESCALER_MODE_ADDR: prescaler_mode_reg_r <= cpu_req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Prescaler free-runs from reset, not aligned to start; first tick may lag
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 6'h01;
    end
  end

  // Tick when the low bits selected by the clock field roll over
  always_comb begin
    unique case (prescaler_mode_reg_r[1:0])
      2'b00: tick = (presc_r[2:0] == 3'h7);
      2'b01: tick = (presc_r[3:0] == 4'hF);
      2'b10: tick = (presc_r[4:0] == 5'h1F);
      2'b11: tick = (presc_r[5:0] == 6'h3F);
    endcase
  end

  // ==========================================================================
  // Free-running counter: cleared when stopped, wraps silently
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count_r <= 16'h0000;
    end else if (!run) begin
      count_r <= 16'h0000;
    end else if (tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      free_run_counter <= 16'h0000;
    end else begin
      free_run_counter <= count_r;
    end
  end

  // ==========================================================================
  // Three identical channels; only the third uses the divider
  assign pins = {capture_input2, capture_input1, capture_input0};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_chan
      capture_channel u_chan (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin_in   (pins[i]),
        .tick     (tick),
        .run      (run),
        .edge_sel (edge_sel_type'(prescaler_mode_reg_r[`EDGE_FIELD_LSB+2*i +: 2])),
        .div_sel  (capture_pulse_control_reg_r[1:0]),
        .use_div  (i == 2),
        .count    (count_r),
        .cap_r    (caps[i]),
        .irq_r    (irqs[i])
      );
    end
  endgenerate

  assign capture_irq0 = irqs[0];
  assign capture_irq1 = irqs[1];
  assign capture_irq2 = irqs[2];

  // ==========================================================================
  // Read path: one-cycle registered answer; unmapped reads give zero
  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.ack = cpu_req.rd | cpu_req.wr;
    if (cpu_req.rd) begin
      unique case (cpu_req.addr)
        `MODE_CONTROL_ADDR:   rsp_nxt.rdata = {8'h00, mode_control_reg_r};
        `CAPTURE_DIV_ADDR:    rsp_nxt.rdata = {8'h00, capture_pulse_control_reg_r};
        `PRESCALER_MODE_ADDR: rsp_nxt.rdata = {8'h00, prescaler_mode_reg_r};
        `CAPTURE0_ADDR:       rsp_nxt.rdata = caps[0];
        `CAPTURE1_ADDR:       rsp_nxt.rdata = caps[1];
        `CAPTURE2_ADDR:       rsp_nxt.rdata = caps[2];
        default:              rsp_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign cpu_rsp = rsp_r;

  // ==========================================================================
  // Checks on the counter, prescaler, control registers and bus answer
  property p_stop_clears;
    @(posedge core_clk) disable iff (!nrst)
    !run |=> (count_r == 16'h0000);
  endproperty
  a_stop_clears: assert property (p_stop_clears)
    else $error("counter not cleared while stopped");

  property p_count_step;
    @(posedge core_clk) disable iff (!nrst)
    run && tick |=> (count_r == $past(count_r) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step on tick");

  property p_hold_no_tick;
    @(posedge core_clk) disable iff (!nrst)
    run && !tick |=> (count_r == $past(count_r));
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick)
    else $error("counter moved without tick");

  property p_wrap;
    @(posedge core_clk) disable iff (!nrst)
    run && tick && (count_r == 16'hFFFF) |=> (count_r == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap");

  // Seven quiet clocks follow every tick at the fastest ratio
  property p_div8_tick;
    @(posedge core_clk) disable iff (!nrst)
    (prescaler_mode_reg_r[1:0] == 2'b00) && tick |=> (!tick)[*7];
  endproperty
  a_div8_tick: assert property (p_div8_tick)
    else $error("fastest tick spacing wrong");

  property p_reset_regs;
    @(posedge core_clk)
    !nrst |=> (mode_control_reg_r == 8'h00) && (prescaler_mode_reg_r == 8'h00)
              && (capture_pulse_control_reg_r == 8'h00);
  endproperty
  a_reset_regs: assert property (p_reset_regs)
    else $error("control registers not cleared");

  // Unused control bits can never be set, whatever software writes
  property p_mode_mask;
    @(posedge core_clk) disable iff (!nrst)
    (mode_control_reg_r & 8'hFB) == 8'h00;
  endproperty
  a_mode_mask: assert property (p_mode_mask)
    else $error("unused mode bit set");

  property p_div_mask;
    @(posedge core_clk) disable iff (!nrst)
    capture_pulse_control_reg_r[7:2] == 6'h00;
  endproperty
  a_div_mask: assert property (p_div_mask)
    else $error("unused divider bit set");

  // Every bus request is answered exactly one cycle later
  property p_ack_pulse;
    @(posedge core_clk) disable iff (!nrst)
    cpu_req.rd || cpu_req.wr |=> cpu_rsp.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("request not acknowledged");

  property p_ack_idle;
    @(posedge core_clk) disable iff (!nrst)
    !(cpu_req.rd || cpu_req.wr) |=> !cpu_rsp.ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("acknowledge without request");

  property p_out_copy;
    @(posedge core_clk) disable iff (!nrst)
    nrst |=> (free_run_counter == $past(count_r));
  endproperty
  a_out_copy: assert property (p_out_copy)
    else $error("counter output not one cycle behind");
endmodule : capture_timer

// ### hw/capture_timer_map.svh
// Register offsets, field positions, reset values and timing counts of the capture timer
`ifndef CAPTURE_TIMER_MAP_SVH
`define CAPTURE_TIMER_MAP_SVH

// ==========================================================================
// Register addresses
`define PRESCALER_MODE_ADDR 16'hFF61
`define MODE_CONTROL_ADDR   16'hFF65
`define CAPTURE_DIV_ADDR    16'hFF67
`define CAPTURE0_ADDR       16'hFF68
`define CAPTURE1_ADDR       16'hFF6A
`define CAPTURE2_ADDR       16'hFF6C

// ==========================================================================
// Fields and reset values
`define RUN_ENABLE_BIT      2
`define CTRL_RESET          8'h00
`define MODE_CONTROL_MASK   8'h04
`define CAPTURE_DIV_MASK    8'h03
`define EDGE_FIELD_LSB      2

// ==========================================================================
// Prescaler: count tick every 2^(SHIFT_BASE+sel) main clocks
`define PRESCALE_SHIFT_BASE 3
`define PRESCALE_WIDTH      6

`endif

// ### hw/capture_timer_pkg.sv
// Types shared by the capture timer design
package capture_timer_pkg;
  typedef enum logic [1:0] {
    EDGE_FALL    = 2'b00,
    EDGE_RISE    = 2'b01,
    EDGE_BAD     = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_sel_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_type;

  typedef struct packed {
    logic [15:0] rdata;
    logic        ack;
  } cpu_rsp_type;
endpackage : capture_timer_pkg

// ### tb/pulse_source.sv
// Behavioural source of the three capture input pulses
`timescale 1ns/10ps
module pulse_source (
  input  wire logic       core_clk,
  output logic      [2:0] pins
);
  // ==========================================================================
  // Pins idle low, so starting the timer never sees a stray high level
  initial pins = 3'h0;

  // Caller stands just after a falling edge, well away from sampling
  task automatic flip(input int ch);
    pins[ch] = ~pins[ch];
  endtask : flip
endmodule : pulse_source

// ### tb/test_capture_timer.sv
// Self-checking bench of the three-channel capture timer
`timescale 1ns/10ps
`include "capture_timer_map.svh"
module test_capture_timer;
  import capture_timer_pkg::*;
  logic        core_clk, nrst;
  cpu_req_type req;
  cpu_rsp_type rsp;
  logic [2:0]  pins, irq;
  logic [15:0] cnt, rd_v, c0;
  int          n_mismatch, n_compared, cycles;
  int          irq_cnt [3];

  capture_timer dut (.core_clk(core_clk), .nrst(nrst), .cpu_req(req), .cpu_rsp(rsp),
    .capture_input0(pins[0]), .capture_input1(pins[1]), .capture_input2(pins[2]),
    .capture_irq0(irq[0]), .capture_irq1(irq[1]), .capture_irq2(irq[2]),
    .free_run_counter(cnt));
  pulse_source src (.core_clk(core_clk), .pins(pins));

  // ==========================================================================
  // Clock, request counting and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (nrst) for (int i = 0; i < 3; i++) irq_cnt[i] += irq[i];
    if (cycles == 60000) begin
      n_mismatch++;
      results();
    end
  end

  // ==========================================================================
  // Shared compare, bus cycles and timer setup
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk) req = '{1'b0, 1'b1, a, d};
    @(negedge core_clk) req = '0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge core_clk) req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge core_clk) req = '0;
    check(rsp.ack, 1'b1, "ack");
    rd_v = rsp.rdata;
  endtask : rd
  // Stop first, since mode and edge changes are unsafe while counting
  task automatic go(input logic [7:0] prm);
    wr(`MODE_CONTROL_ADDR, 8'h00);
    wr(`PRESCALER_MODE_ADDR, prm);
    wr(`MODE_CONTROL_ADDR, 8'h04);
    repeat (24) @(negedge core_clk);
  endtask : go

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd(`MODE_CONTROL_ADDR);   check(rd_v, 16'h0000, "mode reset");
    rd(`CAPTURE_DIV_ADDR);    check(rd_v, 16'h0000, "div reset");
    rd(`PRESCALER_MODE_ADDR); check(rd_v, 16'h0000, "prm reset");
    rd(16'hFF00);             check(rd_v, 16'h0000, "unmapped");
    wr(`CAPTURE_DIV_ADDR, 8'hFF);
    rd(`CAPTURE_DIV_ADDR);    check(rd_v, 16'h0003, "div bits");
    wr(`CAPTURE_DIV_ADDR, 8'h00);
  endtask : t_regs
  // One increment per count tick at every divide ratio, cleared when stopped
  task automatic t_clock();
    for (int s = 0; s < 4; s++) begin
      go(8'(s));
      repeat (3 << (3 + s)) @(negedge core_clk);
      c0 = cnt;
      repeat (8 << s) @(negedge core_clk);
      check(cnt, c0 + 16'h0001, "tick rate");
    end
    wr(`MODE_CONTROL_ADDR, 8'h00);
    repeat (2) @(negedge core_clk);
    check(cnt, 16'h0000, "stop clears");
  endtask : t_clock
  // Both edges on channel 0: captures five ticks apart, counter never cleared
  task automatic t_width();
    go(8'h0C);
    irq_cnt[0] = 0;
    src.flip(0);
    repeat (38) @(negedge core_clk);
    rd(`CAPTURE0_ADDR);
    c0 = rd_v;
    src.flip(0);
    repeat (38) @(negedge core_clk);
    rd(`CAPTURE0_ADDR);
    check(rd_v - c0, 16'h0005, "width");
    check(irq_cnt[0], 2, "irq count");
  endtask : t_width
  // Every edge code on channel 1, then a glitch shorter than two samples
  task automatic t_edges();
    logic [1:0] code [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    int         exp [4] = '{1, 1, 2, 0};
    for (int k = 0; k < 4; k++) begin
      go({2'b00, code[k], 4'h0});
      irq_cnt[1] = 0;
      src.flip(1);
      repeat (40) @(negedge core_clk);
      src.flip(1);
      repeat (40) @(negedge core_clk);
      check(irq_cnt[1], exp[k], "edge code");
    end
    go(8'h30);
    irq_cnt[1] = 0;
    src.flip(1);
    repeat (4) @(negedge core_clk);
    src.flip(1);
    repeat (40) @(negedge core_clk);
    check(irq_cnt[1], 0, "glitch");
  endtask : t_edges
  // Eight rising pulses on channel 2 through each divide ratio
  task automatic t_div();
    for (int d = 0; d < 4; d++) begin
      wr(`MODE_CONTROL_ADDR, 8'h00);
      wr(`CAPTURE_DIV_ADDR, 8'(d));
      go(8'h40);
      irq_cnt[2] = 0;
      repeat (16) begin
        src.flip(2);
        repeat (24) @(negedge core_clk);
      end
      check(irq_cnt[2], 8 >> d, "divider");
    end
  endtask : t_div
  // A high pin at start fakes a rising capture; a low pin does not
  task automatic t_start();
    wr(`MODE_CONTROL_ADDR, 8'h00);
    src.flip(0);
    irq_cnt[0] = 0;
    go(8'h04);
    check(irq_cnt[0], 1, "start high");
    wr(`MODE_CONTROL_ADDR, 8'h00);
    src.flip(0);
    irq_cnt[0] = 0;
    go(8'h04);
    check(irq_cnt[0], 0, "start low");
  endtask : t_start

  // ==========================================================================
  // Verdict and main sequence
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    nrst = 1'b0;
    req = '0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'b1;
    t_regs();
    t_clock();
    t_width();
    t_edges();
    t_div();
    t_start();
    results();
  end
endmodule : test_capture_timer
